/* rtl/lic_led_irq_ctrl.sv */
`timescale 1ns/1ps
module lic_led_irq_ctrl #(
    parameter logic [4:0] PHY_ADDR       = lic_pkg::PHY_ADDR_DEF,
    parameter int         STRETCH_CYCLES = lic_pkg::STRETCH_CYCLES
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // Serial management pins
    input  wire logic                        mdc,
    input  wire logic                        mdio_in,
    output logic                             mdio_out,
    output logic                             mdio_oe,
    // Link conditions and interrupt sources
    input  wire lic_pkg::lic_link_st_t       link_st,
    input  wire logic [lic_pkg::NUM_SOURCES-1:0] irq_cond,
    // Indicators and interrupt pin
    output logic                             indicator_zero,
    output logic                             indicator_one,
    output logic                             indicator_two,
    output logic                             indicator_three,
    output logic                             irq_pin
);

    localparam int CW = $clog2(STRETCH_CYCLES + 1);
    localparam int NS = lic_pkg::NUM_SOURCES;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] mdc_s;
    logic [2:0] mdio_s;
    logic       mdc_lvl;
    logic       mdc_rise;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mdc_s  <= 3'h0;
            mdio_s <= 3'h0;
        end else begin
            mdc_s  <= {mdc_s[1:0], mdc};
            mdio_s <= {mdio_s[1:0], mdio_in};
        end
    end

    // A level change is only believed once the last two stages agree.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mdc_lvl <= 1'b0;
        end else if (mdc_s[1] == mdc_s[2]) begin
            mdc_lvl <= mdc_s[2];
        end
    end

    assign mdc_rise = (mdc_s[1] == mdc_s[2]) && mdc_s[2] && !mdc_lvl;

    // ----------------------------------------------------------------
    // Management frame engine
    // ----------------------------------------------------------------
    lic_pkg::lic_mgmt_state_t state;
    logic [14:0] hdr_sr;
    logic        is_read;
    logic        addr_hit;
    logic [4:0]  reg_addr;
    logic [4:0]  bit_cnt;
    logic [15:0] data_sr;
    logic        wr_stb;
    logic        rd_stb;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic        hdr_ok;
    logic [14:0] hdr_nx;

    logic [15:0] mode_sel;
    logic [15:0] rsvd_ctrl;
    logic [15:0] irq_ctrl;
    logic [NS-1:0] flags;

    // Preamble bit, start 01, opcode, PHY address, register address.
    // The header is matched with the current bit already in, so the turnaround starts on the next rise.
    assign hdr_nx = {hdr_sr[13:0], mdio_s[2]};
    assign hdr_ok = hdr_nx[14] && (hdr_nx[13:12] == 2'h1) &&
                    ((hdr_nx[11:10] == lic_pkg::OP_READ) || (hdr_nx[11:10] == lic_pkg::OP_WRITE));

    always_comb begin
        unique case (reg_addr)
            lic_pkg::ADDR_MODE_SEL:  rd_data = mode_sel;
            lic_pkg::ADDR_RSVD_CTRL: rd_data = rsvd_ctrl;
            lic_pkg::ADDR_IRQ_CTRL:  rd_data = irq_ctrl;
            lic_pkg::ADDR_IRQ_FLAGS: rd_data = {{(16 - NS){1'b0}}, flags};
            default:                 rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= lic_pkg::LIC_IDLE;
            hdr_sr   <= 15'h0000;
            is_read  <= 1'b0;
            addr_hit <= 1'b0;
            reg_addr <= 5'h00;
            bit_cnt  <= 5'h00;
            data_sr  <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
            wr_stb   <= 1'b0;
            rd_stb   <= 1'b0;
            wr_data  <= 16'h0000;
        end else begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (mdc_rise) begin
                unique case (state)
                    lic_pkg::LIC_IDLE: begin
                        hdr_sr <= hdr_nx;
                        if (hdr_ok) begin
                            is_read  <= (hdr_nx[11:10] == lic_pkg::OP_READ);
                            addr_hit <= (hdr_nx[9:5] == PHY_ADDR);
                            reg_addr <= hdr_nx[4:0];
                            state    <= lic_pkg::LIC_TURN;
                        end
                    end
                    lic_pkg::LIC_TURN: begin
                        // Second turnaround bit is driven low by the device on a read.
                        data_sr <= rd_data;
                        rd_stb  <= is_read && addr_hit;
                        mdio_oe <= is_read && addr_hit;
                        mdio_out <= 1'b0;
                        bit_cnt <= 5'h00;
                        state   <= lic_pkg::LIC_DATA;
                    end
                    lic_pkg::LIC_DATA: begin
                        bit_cnt <= bit_cnt + 5'h01;
                        if (is_read) begin
                            mdio_out <= data_sr[15];
                            data_sr  <= {data_sr[14:0], 1'b0};
                        end else if (bit_cnt != 5'h00) begin
                            data_sr <= {data_sr[14:0], mdio_s[2]};
                        end
                        if (bit_cnt == 5'(lic_pkg::DATA_BITS)) begin
                            mdio_oe <= 1'b0;
                            mdio_out <= 1'b0;
                            wr_stb  <= !is_read && addr_hit;
                            wr_data <= {data_sr[14:0], mdio_s[2]};
                            hdr_sr  <= 15'h0000;
                            state   <= lic_pkg::LIC_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_sel  <= lic_pkg::MODE_SEL_RESET;
            rsvd_ctrl <= lic_pkg::RSVD_CTRL_RESET;
            irq_ctrl  <= lic_pkg::IRQ_CTRL_RESET;
        end else if (wr_stb) begin
            if (reg_addr == lic_pkg::ADDR_MODE_SEL)  mode_sel  <= wr_data;
            if (reg_addr == lic_pkg::ADDR_RSVD_CTRL) rsvd_ctrl <= wr_data;
            if (reg_addr == lic_pkg::ADDR_IRQ_CTRL)  irq_ctrl  <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt flags
    // ----------------------------------------------------------------
    logic [NS-1:0] cond_q;
    logic [NS-1:0] ev_set;
    logic [NS-1:0] ev_clr;

    assign ev_set = irq_cond & ~cond_q;

    always_comb begin
        ev_clr = '0;
        if (irq_ctrl[lic_pkg::IRQ_AUTO_CLR_BIT]) ev_clr = ev_clr | ~irq_cond;
        if (rd_stb && (reg_addr == lic_pkg::ADDR_IRQ_FLAGS) && irq_ctrl[lic_pkg::IRQ_RD_CLR_BIT])
            ev_clr = ev_clr | {NS{1'b1}};
        if (wr_stb && (reg_addr == lic_pkg::ADDR_IRQ_FLAGS)) begin
            if (irq_ctrl[lic_pkg::IRQ_RESETUP_BIT])
                ev_clr = ev_clr | (wr_data[NS-1:0] & ~irq_cond);
            else
                ev_clr = ev_clr | wr_data[NS-1:0];
        end
    end

    // A new event in the clearing cycle survives, so none is lost.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cond_q <= '0;
            flags  <= '0;
        end else begin
            cond_q <= irq_cond;
            flags  <= (flags & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_pin <= 1'b1;
        end else if (irq_ctrl[lic_pkg::IRQ_OUT_EN_BIT] && |(flags & irq_ctrl[NS-1:0])) begin
            irq_pin <= irq_ctrl[lic_pkg::IRQ_POL_BIT];
        end else begin
            irq_pin <= !irq_ctrl[lic_pkg::IRQ_POL_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Indicator drive
    // ----------------------------------------------------------------
    // Traffic pulses last a few cycles only; they are held long enough to see.
    logic [3:0]    trf_raw;
    logic [3:0]    trf_lit;
    logic [CW-1:0] hold [4];

    assign trf_raw = {link_st.collision, link_st.rx_active, link_st.tx_active,
                      link_st.tx_active | link_st.rx_active};

    for (genvar g = 0; g < 4; g++) begin : g_stretch
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                hold[g] <= '0;
            end else if (trf_raw[g]) begin
                hold[g] <= CW'(STRETCH_CYCLES);
            end else if (hold[g] != '0) begin
                hold[g] <= hold[g] - CW'(1);
            end
        end
        assign trf_lit[g] = trf_raw[g] || (hold[g] != '0);
    end

    function automatic logic lic_show(input logic [2:0] sel, input logic off_is_link);
        unique case (sel)
            lic_pkg::SEL_LINK:      lic_show = link_st.link_ok;
            lic_pkg::SEL_ACTIVITY:  lic_show = trf_lit[0];
            lic_pkg::SEL_TX_DATA:   lic_show = trf_lit[1];
            lic_pkg::SEL_RX_DATA:   lic_show = trf_lit[2];
            lic_pkg::SEL_COLLISION: lic_show = trf_lit[3];
            lic_pkg::SEL_SPEED:     lic_show = link_st.speed_100;
            lic_pkg::SEL_DUPLEX:    lic_show = link_st.full_duplex;
            lic_pkg::SEL_OFF:       lic_show = off_is_link && link_st.link_ok;
        endcase
    endfunction

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            indicator_zero  <= 1'b0;
            indicator_one   <= 1'b0;
            indicator_two   <= 1'b0;
            indicator_three <= 1'b0;
        end else begin
            indicator_zero  <= lic_show(mode_sel[lic_pkg::SEL_ZERO_LSB +: 3], 1'b1);
            indicator_one   <= lic_show(mode_sel[lic_pkg::SEL_ONE_LSB +: 3], 1'b0);
            indicator_two   <= lic_show(mode_sel[lic_pkg::SEL_TWO_LSB +: 3], 1'b0);
            indicator_three <= lic_show(mode_sel[lic_pkg::SEL_THREE_LSB +: 3], 1'b0);
        end
    end

endmodule

/* rtl/lic_pkg.sv */
package lic_pkg;

    // ----------------------------------------------------------------
    // Management frame and register addresses
    // ----------------------------------------------------------------
    localparam logic [4:0]  ADDR_MODE_SEL   = 5'h14;
    localparam logic [4:0]  ADDR_RSVD_CTRL  = 5'h15;
    localparam logic [4:0]  ADDR_IRQ_CTRL   = 5'h16;
    localparam logic [4:0]  ADDR_IRQ_FLAGS  = 5'h17;
    localparam logic [4:0]  PHY_ADDR_DEF    = 5'h01;
    localparam logic [1:0]  OP_READ         = 2'h2;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    localparam int          DATA_BITS       = 16;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int          SEL_THREE_LSB   = 9;
    localparam int          SEL_TWO_LSB     = 6;
    localparam int          SEL_ONE_LSB     = 3;
    localparam int          SEL_ZERO_LSB    = 0;
    localparam int          IRQ_OUT_EN_BIT  = 15;
    localparam int          IRQ_RD_CLR_BIT  = 14;
    localparam int          IRQ_POL_BIT     = 13;
    localparam int          IRQ_AUTO_CLR_BIT = 12;
    localparam int          IRQ_RESETUP_BIT = 11;
    localparam int          NUM_SOURCES     = 11;
    localparam logic [15:0] MODE_SEL_RESET  = 16'h3FE9;
    localparam logic [15:0] RSVD_CTRL_RESET = 16'h0000;
    localparam logic [15:0] IRQ_CTRL_RESET  = 16'h0000;

    // ----------------------------------------------------------------
    // Indicator selector codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  SEL_LINK        = 3'h0;
    localparam logic [2:0]  SEL_ACTIVITY    = 3'h1;
    localparam logic [2:0]  SEL_TX_DATA     = 3'h2;
    localparam logic [2:0]  SEL_RX_DATA     = 3'h3;
    localparam logic [2:0]  SEL_COLLISION   = 3'h4;
    localparam logic [2:0]  SEL_SPEED       = 3'h5;
    localparam logic [2:0]  SEL_DUPLEX      = 3'h6;
    localparam logic [2:0]  SEL_OFF         = 3'h7;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam longint      STRETCH_NS      = 40000000;
    localparam longint      CLK_PERIOD_NS   = 5;
    localparam int          STRETCH_CYCLES  = int'((STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Link and traffic conditions feeding the indicators
    // ----------------------------------------------------------------
    typedef struct packed {
        logic link_ok;
        logic speed_100;
        logic full_duplex;
        logic tx_active;
        logic rx_active;
        logic collision;
    } lic_link_st_t;

    typedef enum logic [1:0] {
        LIC_IDLE,
        LIC_TURN,
        LIC_DATA
    } lic_mgmt_state_t;

endpackage

/* verif/lic_led_irq_ctrl_asserts.sv */
`timescale 1ns/1ps
module lic_led_irq_ctrl_asserts #(parameter int STRETCH_CYCLES = lic_pkg::STRETCH_CYCLES) (
    // Clock and reset
    input wire logic                             clk,
    input wire logic                             rst_b,
    // Management pins
    input wire logic                             mdc,
    input wire logic                             mdio_in,
    input wire logic                             mdio_out,
    input wire logic                             mdio_oe,
    // Conditions
    input wire lic_pkg::lic_link_st_t            link_st,
    input wire logic [lic_pkg::NUM_SOURCES-1:0] irq_cond,
    // Indicators and interrupt pin
    input wire logic                             indicator_zero,
    input wire logic                             indicator_one,
    input wire logic                             indicator_two,
    input wire logic                             indicator_three,
    input wire logic                             irq_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // No write frame can land this soon, so selectors and control still hold reset values.
    logic [7:0] since_rst;
    logic       early;
    logic       act;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            since_rst <= 8'h00;
        end else if (since_rst != 8'hFF) begin
            since_rst <= since_rst + 8'h01;
        end
    end
    assign early = since_rst < 8'h96;
    assign act = link_st.tx_active | link_st.rx_active;
    property p_rst_vals; $rose(rst_b) |-> !mdio_oe && !indicator_zero && irq_pin; endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not at reset levels");
    property p_irq_idle; early |-> irq_pin; endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq pin active while disabled");
    property p_three_off; early |-> !indicator_three; endproperty
    a_three_off: assert property (p_three_off) else $error("indicator three lit");
    property p_two_off; early |-> !indicator_two; endproperty
    a_two_off: assert property (p_two_off) else $error("indicator two lit");
    property p_one_speed; early |=> indicator_one == $past(link_st.speed_100); endproperty
    a_one_speed: assert property (p_one_speed) else $error("indicator one not speed");
    property p_zero_act; early && act |=> indicator_zero; endproperty
    a_zero_act: assert property (p_zero_act) else $error("indicator zero missed activity");
    property p_zero_hold; early && $past(rst_b) && $fell(act) |=> indicator_zero [*4]; endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("activity not stretched");
    property p_ta_low; $rose(mdio_oe) |-> (mdio_oe && !mdio_out) [*6]; endproperty
    a_ta_low: assert property (p_ta_low) else $error("turnaround bit not low");
    c_read: cover property ($rose(mdio_oe));
    c_irq: cover property (!early && $changed(irq_pin));
    c_three: cover property ($rose(indicator_three));
endmodule
bind lic_led_irq_ctrl lic_led_irq_ctrl_asserts #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (
    .clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .link_st(link_st), .irq_cond(irq_cond), .indicator_zero(indicator_zero), .indicator_one(indicator_one),
    .indicator_two(indicator_two), .indicator_three(indicator_three), .irq_pin(irq_pin));

/* verif/lic_mgmt_host.sv */
`timescale 1ns/1ps
module lic_mgmt_host (
    // Clock and pace
    input  wire logic   clk,
    input  wire logic   slow,
    // Device side of the data pin
    input  wire logic   mdio_out,
    input  wire logic   mdio_oe,
    // Pins towards the device
    output logic        mdc,
    output logic        mdio_in,
    // Read results
    output logic        rd_done,
    output logic [15:0] rd_data
);
    logic host_oe;
    logic host_bit;
    // A pull-up holds the released line high, so an unanswered read returns all ones.
    assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_bit : 1'b1);
    initial begin
        mdc = 1'b0;
        host_oe = 1'b0;
        host_bit = 1'b1;
        rd_done = 1'b0;
        rd_data = 16'h0000;
    end
    // Mdc stands low between frames; a half period is 3 clocks when prompt, 8 when slow.
    task automatic bit_cyc(input logic b, output logic s);
        host_bit <= b;
        repeat (slow ? 8 : 3) @(posedge clk);
        mdc <= 1'b1;
        s = mdio_in;
        repeat (slow ? 8 : 3) @(posedge clk);
        mdc <= 1'b0;
    endtask
    // Preamble, start, opcode, addresses, turnaround and data, msb first.
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
        logic [33:0] f;
        logic [15:0] got;
        logic        s;
        f = {4'hD, op, phy, ra, 2'h2, wd};
        got = 16'h0000;
        host_oe <= 1'b1;
        for (int i = 33; i >= 0; i--) begin
            if (op == lic_pkg::OP_READ && i == 17) begin
                host_oe <= 1'b0;
            end
            bit_cyc(f[i], s);
            got = {got[14:0], s};
        end
        host_oe <= 1'b0;
        repeat (8) @(posedge clk);
        if (op == lic_pkg::OP_READ) begin
            rd_data <= got;
            rd_done <= 1'b1;
            @(posedge clk);
            rd_done <= 1'b0;
        end
    endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk, rst_b, mdc, mdio_in, mdio_out, mdio_oe, slow, rd_done, irq_pin;
    logic [15:0]           rd_data;
    lic_pkg::lic_link_st_t link_st;
    logic [10:0]           irq_cond;
    logic [3:0]            ind;
    logic [15:0]           exp_q[$];
    logic [31:0]           r;
    logic [15:0]           m;
    int n_mismatch, samples_checked, seed, src;
    lic_led_irq_ctrl #(.PHY_ADDR(lic_pkg::PHY_ADDR_DEF), .STRETCH_CYCLES(8)) dut (
        .clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .link_st(link_st), .irq_cond(irq_cond), .indicator_zero(ind[0]), .indicator_one(ind[1]),
        .indicator_two(ind[2]), .indicator_three(ind[3]), .irq_pin(irq_pin));
    lic_mgmt_host host (.clk(clk), .slow(slow), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
        .mdio_in(mdio_in), .rd_done(rd_done), .rd_data(rd_data));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        if (rd_done === 1'b1 && exp_q.size() > 0) begin
            check("read data", rd_data, exp_q.pop_front());
        end
    end
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        host.frame(lic_pkg::OP_WRITE, lic_pkg::PHY_ADDR_DEF, ra, d);
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] e, input logic [4:0] phy = lic_pkg::PHY_ADDR_DEF);
        exp_q.push_back(e);
        host.frame(lic_pkg::OP_READ, phy, ra, 16'h0000);
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
        if (exp_q.size() > 0) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic pin(input logic e);
        repeat (4) @(posedge clk);
        check("irq_pin", {15'h0, irq_pin}, {15'h0, e});
    endtask
    initial begin
        seed = 32'h3E9E;
        rst_b = 1'b0;
        slow = 1'b1;
        link_st = 6'h00;
        irq_cond = 11'h000;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        link_st <= 6'h14;
        repeat (2) @(posedge clk);
        link_st <= 6'h10;
        rd(5'h14, 16'h3FE9);
        rd(5'h15, 16'h0000);
        rd(5'h16, 16'h0000);
        rd(5'h10, 16'h0000);
        rd(5'h14, 16'hFFFF, 5'h02);
        $display("test reset_values done");
        slow = 1'b0;
        r = $random(seed);
        wr(5'h15, r[15:0]);
        rd(5'h15, r[15:0]);
        wr(5'h15, 16'h0000);
        $display("test storage done");
        // ----------------------------------------------------------------
        // Every selector code on all four indicators at once
        // ----------------------------------------------------------------
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            link_st <= r[5:0];
            wr(5'h14, {4'h0, {4{k[2:0]}}});
            m = {9'h0, link_st.full_duplex, link_st.speed_100, link_st.collision, link_st.rx_active,
                 link_st.tx_active, link_st.tx_active | link_st.rx_active, link_st.link_ok};
            for (int j = 0; j < 4; j++) begin
                check("indicator", {15'h0, ind[j]}, {15'h0, (k == 7 && j == 0) ? link_st.link_ok : m[k]});
            end
        end
        rd(5'h14, 16'h0FFF);
        $display("test selectors done");
        // ----------------------------------------------------------------
        // Interrupt pin, flags and their clearing modes on a random source
        // ----------------------------------------------------------------
        r = $random(seed);
        src = int'(r[15:0] % 16'hB);
        m = (16'h1 << src) | (16'h1 << ((src + 1) % 11));
        wr(5'h16, 16'h8000 | (16'h1 << src));
        pin(1'b1);
        irq_cond <= m[10:0];
        pin(1'b0);
        irq_cond <= 11'h000;
        rd(5'h17, m);
        pin(1'b0);
        wr(5'h17, 16'h1 << src);
        pin(1'b1);
        wr(5'h17, 16'h07FF);
        wr(5'h16, 16'hB000 | (16'h1 << src));
        pin(1'b0);
        irq_cond[src] <= 1'b1;
        pin(1'b1);
        irq_cond[src] <= 1'b0;
        pin(1'b0);
        wr(5'h16, 16'hC800 | (16'h1 << src));
        irq_cond[src] <= 1'b1;
        wr(5'h17, 16'h1 << src);
        rd(5'h17, 16'h1 << src);
        rd(5'h17, 16'h0000);
        irq_cond[src] <= 1'b0;
        wr(5'h16, 16'h1 << src);
        irq_cond[src] <= 1'b1;
        pin(1'b1);
        $display("test interrupts done");
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        irq_cond <= 11'h000;
        repeat (4) @(posedge clk);
        rd(5'h16, 16'h0000);
        rd(5'h17, 16'h0000);
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule
